// *** hw/trap_unit_pkg.sv ***
// Encodings and constants for the trap and system-call unit
package trap_unit_pkg;
    // ==========================================================
    // Instruction fields
    localparam int OP_HI = 31;
    localparam int OP_LO = 26;
    localparam int FS_HI = 25;
    localparam int FS_LO = 21;
    localparam int SS_HI = 20;
    localparam int SS_LO = 16;
    localparam int IMM_HI = 15;
    localparam int IMM_LO = 0;
    localparam int FN_HI = 5;
    localparam int FN_LO = 0;
    localparam int IMM_W = 16;
    // ==========================================================
    // Major opcodes
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_IMMEDIATE_BRANCH = 6'h01;
    // ==========================================================
    // Function codes
    localparam logic [5:0] FN_SYSTEM_CALL = 6'h0C;
    localparam logic [5:0] FN_TRAP_EQ_REG = 6'h34;
    localparam logic [5:0] FN_TRAP_GE_REG = 6'h30;
    localparam logic [5:0] FN_TRAP_GEU_REG = 6'h31;
    // ==========================================================
    // Immediate sub-codes
    localparam logic [4:0] SUB_TRAP_EQ_IMM = 5'h0C;
    localparam logic [4:0] SUB_TRAP_GE_IMM = 5'h08;
    localparam logic [4:0] SUB_TRAP_GEU_IMM = 5'h09;
endpackage

// *** hw/trap_and_system_call_instr_unit.sv ***
// Trap and system-call decode and condition evaluation
`timescale 1ns/1ps

// Operation
// RULE1: A system-call instruction raises a system-call exception unconditionally.
// RULE2: The system-call parameter field is ignored by the hardware.
// RULE3: Register trap-if-equal traps when both source registers are equal.
// RULE4: Register trap-if-greater-or-equal traps on signed first >= second.
// RULE5: Unsigned register trap-if-greater-or-equal traps on unsigned first >= second.
// RULE6: The 10-bit code field of register traps is ignored by the hardware.
// RULE7: Immediate trap-if-equal traps when the source equals the sign-extended immediate.
// RULE8: Immediate trap-if-greater-or-equal traps on signed source >= sign-extended immediate.
// RULE9: Unsigned immediate trap sign-extends the immediate then compares unsigned.
// RULE10: The unsigned immediate thus covers 0..32767 and the top 32768 unsigned values.
// RULE11: Immediate trap forms are not implemented in a Release 6 configuration.
// RULE12: A false trap condition completes with no exception and no side effect.
// RULE13: In Release 6 the removed immediate forms raise a reserved-instruction exception.
module trap_and_system_call_instr_unit #(
    parameter int DATA_W = 64,
    parameter bit RELEASE6 = 1'b0
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Instruction issue
    input wire logic i_valid,
    input wire logic [31:0] i_instr,
    input wire logic [DATA_W-1:0] i_first_source,
    input wire logic [DATA_W-1:0] i_second_source,
    // Completion flag and exception requests, one cycle after issue
    output logic o_done,
    output logic o_system_call,
    output logic o_trap,
    output logic o_reserved_instr
);
    // ==========================================================
    // Reset release
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ==========================================================
    // Helpers
    // Sign bit is copied upward so the unsigned form still reaches the top of the range
    function automatic logic [DATA_W-1:0] sext_imm(input logic [trap_unit_pkg::IMM_W-1:0] imm);
        sext_imm = {{(DATA_W-trap_unit_pkg::IMM_W){imm[trap_unit_pkg::IMM_W-1]}}, imm};
    endfunction

    // Decoders shared by the checks below
    function automatic logic is_special_fn(input logic [31:0] w, input logic [5:0] code);
        is_special_fn = (w[trap_unit_pkg::OP_HI:trap_unit_pkg::OP_LO] == trap_unit_pkg::OP_SPECIAL)
            && (w[trap_unit_pkg::FN_HI:trap_unit_pkg::FN_LO] == code);
    endfunction

    function automatic logic is_imm_sub(input logic [31:0] w, input logic [4:0] code);
        is_imm_sub = (w[trap_unit_pkg::OP_HI:trap_unit_pkg::OP_LO] == trap_unit_pkg::OP_IMMEDIATE_BRANCH)
            && (w[trap_unit_pkg::SS_HI:trap_unit_pkg::SS_LO] == code);
    endfunction

    function automatic logic sge(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        sge = $signed(a) >= $signed(b);
    endfunction

    // ==========================================================
    // Decode and evaluate
    logic [5:0] opc;
    logic [5:0] fn;
    logic [4:0] sub;
    logic [DATA_W-1:0] imm_x;
    logic done_nxt;
    logic sys_nxt;
    logic trap_nxt;
    logic ri_nxt;
    logic done_r;
    logic sys_r;
    logic trap_r;
    logic ri_r;

    always_comb begin
        opc = i_instr[trap_unit_pkg::OP_HI:trap_unit_pkg::OP_LO];
        fn = i_instr[trap_unit_pkg::FN_HI:trap_unit_pkg::FN_LO];
        sub = i_instr[trap_unit_pkg::SS_HI:trap_unit_pkg::SS_LO];
        imm_x = sext_imm(i_instr[trap_unit_pkg::IMM_HI:trap_unit_pkg::IMM_LO]); // RULE9 RULE10
        done_nxt = i_valid;
        sys_nxt = 1'b0;
        trap_nxt = 1'b0; // RULE12
        ri_nxt = 1'b0;
        if (i_valid && opc == trap_unit_pkg::OP_SPECIAL) begin
            // Bits 25..6 never enter a decision: code fields stay software's
            case (fn)
                trap_unit_pkg::FN_SYSTEM_CALL: sys_nxt = 1'b1; // RULE1 RULE2
                trap_unit_pkg::FN_TRAP_EQ_REG: trap_nxt = i_first_source == i_second_source; // RULE3 RULE6
                trap_unit_pkg::FN_TRAP_GE_REG: trap_nxt = sge(i_first_source, i_second_source); // RULE4
                trap_unit_pkg::FN_TRAP_GEU_REG: trap_nxt = i_first_source >= i_second_source; // RULE5
                default: trap_nxt = 1'b0;
            endcase
        end else if (i_valid && opc == trap_unit_pkg::OP_IMMEDIATE_BRANCH) begin
            case (sub)
                trap_unit_pkg::SUB_TRAP_EQ_IMM: begin
                    ri_nxt = RELEASE6; // RULE11 RULE13
                    trap_nxt = !RELEASE6 && i_first_source == imm_x; // RULE7
                end
                trap_unit_pkg::SUB_TRAP_GE_IMM: begin
                    ri_nxt = RELEASE6; // RULE11 RULE13
                    trap_nxt = !RELEASE6 && sge(i_first_source, imm_x); // RULE8
                end
                trap_unit_pkg::SUB_TRAP_GEU_IMM: begin
                    ri_nxt = RELEASE6; // RULE11 RULE13
                    trap_nxt = !RELEASE6 && i_first_source >= imm_x; // RULE9
                end
                default: ri_nxt = 1'b0;
            endcase
        end
    end

    // Registered so every output comes from a flip-flop; one cycle latency
    always_ff @(posedge i_mclk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            done_r <= 1'b0;
            sys_r <= 1'b0;
            trap_r <= 1'b0;
            ri_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
            sys_r <= sys_nxt;
            trap_r <= trap_nxt;
            ri_r <= ri_nxt;
        end
    end

    assign o_done = done_r;
    assign o_system_call = sys_r;
    assign o_trap = trap_r;
    assign o_reserved_instr = ri_r;

    // ==========================================================
    // Checks
    // One sequence per instruction kind; the per-form immediate sequences only count outside Release 6, s_issue_removed counts in both
    sequence s_issue_system_call_instr;
        i_valid && is_special_fn(i_instr, trap_unit_pkg::FN_SYSTEM_CALL);
    endsequence

    sequence s_issue_teq;
        i_valid && is_special_fn(i_instr, trap_unit_pkg::FN_TRAP_EQ_REG);
    endsequence

    sequence s_issue_tge;
        i_valid && is_special_fn(i_instr, trap_unit_pkg::FN_TRAP_GE_REG);
    endsequence

    sequence s_issue_trap_geu_reg;
        i_valid && is_special_fn(i_instr, trap_unit_pkg::FN_TRAP_GEU_REG);
    endsequence

    sequence s_issue_removed;
        i_valid && (is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_EQ_IMM)
            || is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_GE_IMM)
            || is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_GEU_IMM));
    endsequence

    sequence s_legacy_trap_eq_imm;
        !RELEASE6 && i_valid && is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_EQ_IMM);
    endsequence

    sequence s_legacy_trap_ge_imm;
        !RELEASE6 && i_valid && is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_GE_IMM);
    endsequence

    sequence s_legacy_trap_geu_imm;
        !RELEASE6 && i_valid && is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_GEU_IMM);
    endsequence

    // Anything that is neither a trap nor a system call must only complete
    sequence s_issue_plain;
        i_valid && !is_special_fn(i_instr, trap_unit_pkg::FN_SYSTEM_CALL)
        && !is_special_fn(i_instr, trap_unit_pkg::FN_TRAP_EQ_REG)
        && !is_special_fn(i_instr, trap_unit_pkg::FN_TRAP_GE_REG)
        && !is_special_fn(i_instr, trap_unit_pkg::FN_TRAP_GEU_REG)
        && !is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_EQ_IMM)
        && !is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_GE_IMM)
        && !is_imm_sub(i_instr, trap_unit_pkg::SUB_TRAP_GEU_IMM);
    endsequence

    a_system_call_instr_always: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE1 RULE2
        s_issue_system_call_instr |=> o_system_call && !o_trap)
        else $error("system call not raised");

    a_teq_reg: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE3
        s_issue_teq |=> o_trap == $past(i_first_source == i_second_source))
        else $error("equal trap wrong");

    a_tge_reg: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE4
        s_issue_tge |=> o_trap == $past($signed(i_first_source) >= $signed(i_second_source)))
        else $error("signed trap wrong");

    a_trap_geu_reg_reg: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE5
        s_issue_trap_geu_reg |=> o_trap == $past(i_first_source >= i_second_source))
        else $error("unsigned trap wrong");

    a_imm_release6: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE13
        s_issue_removed |=> o_reserved_instr == RELEASE6 && !(RELEASE6 && o_trap))
        else $error("release gating wrong");

    a_teq_imm: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE7
        s_legacy_trap_eq_imm |=> o_trap
            == $past(i_first_source == DATA_W'($signed(i_instr[trap_unit_pkg::IMM_HI:trap_unit_pkg::IMM_LO]))))
        else $error("equal immediate trap wrong");

    a_tge_imm: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE8
        s_legacy_trap_ge_imm |=> o_trap == $past($signed(i_first_source)
            >= $signed(DATA_W'($signed(i_instr[trap_unit_pkg::IMM_HI:trap_unit_pkg::IMM_LO])))))
        else $error("signed immediate trap wrong");

    a_trap_geu_reg_imm: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE9
        s_legacy_trap_geu_imm |=> o_trap
            == $past(i_first_source >= DATA_W'($signed(i_instr[trap_unit_pkg::IMM_HI:trap_unit_pkg::IMM_LO]))))
        else $error("unsigned immediate trap wrong");

    a_idle_quiet: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE12
        !i_valid |=> !o_done && !o_trap && !o_system_call && !o_reserved_instr)
        else $error("exception without issue");

    a_plain_quiet: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE12
        s_issue_plain |=> o_done && !o_trap && !o_system_call && !o_reserved_instr)
        else $error("plain instruction raised exception");

    a_done_follows: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE12
        i_valid |=> o_done)
        else $error("issue not completed");

    // The core's exception logic takes one cause per instruction
    a_single_exception: assert property (@(posedge i_mclk) disable iff (!rst_sync_r) // RULE12
        $onehot0({o_system_call, o_trap, o_reserved_instr}))
        else $error("more than one exception");
endmodule

// *** bench/gpr_file_model.sv ***
// Register file model that feeds source operands to the trap unit
`timescale 1ns/1ps
module gpr_file_model #(
    parameter int DATA_W = 64
) (
    // Clock and write port
    input wire logic i_mclk,
    input wire logic i_we,
    input wire logic [4:0] i_idx,
    input wire logic [DATA_W-1:0] i_data,
    // Read side, indexed by the issued word
    input wire logic [31:0] i_instr,
    output logic [DATA_W-1:0] o_first,
    output logic [DATA_W-1:0] o_second
);
    logic [DATA_W-1:0] regs_r [32];
    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            regs_r[i_idx] <= i_data;
        end
    end
    // Entry zero is hardwired, so stale writes there never leak into a compare
    assign o_first = (i_instr[25:21] == 5'h00) ? '0 : regs_r[i_instr[25:21]];
    assign o_second = (i_instr[20:16] == 5'h00) ? '0 : regs_r[i_instr[20:16]];
endmodule

// *** bench/trap_and_system_call_instr_unit_tb.sv ***
// Self-checking bench for the trap and system-call unit
`timescale 1ns/1ps
module trap_and_system_call_instr_unit_tb;
    // ==========================================================
    // Stimulus and wiring
    logic i_mclk = 1'h0, i_rst_n = 1'h0, valid = 1'h0, we = 1'h0;
    logic [31:0] instr = '0;
    logic [4:0] idx = '0;
    logic [63:0] wdata = '0, first, second;
    logic done, sc, tr, ri, done6, sc6, tr6, ri6;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
    initial forever #20 i_mclk = ~i_mclk;
    gpr_file_model u_gpr(.i_mclk(i_mclk), .i_we(we), .i_idx(idx), .i_data(wdata), .i_instr(instr),
        .o_first(first), .o_second(second));
    trap_and_system_call_instr_unit u_dut(.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(valid), .i_instr(instr),
        .i_first_source(first), .i_second_source(second), .o_done(done), .o_system_call(sc),
        .o_trap(tr), .o_reserved_instr(ri));
    // Second copy in the newer release to see the removed encodings refused
    trap_and_system_call_instr_unit #(.RELEASE6(1'h1)) u_dut6(.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(valid),
        .i_instr(instr), .i_first_source(first), .i_second_source(second), .o_done(done6),
        .o_system_call(sc6), .o_trap(tr6), .o_reserved_instr(ri6));
    // ==========================================================
    // Shared tasks
    task chk(input string nm, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task regs(input logic [63:0] a, input logic [63:0] b);
        @(negedge i_mclk);
        we = 1'h1;
        idx = 5'h01;
        wdata = a;
        @(negedge i_mclk);
        idx = 5'h02;
        wdata = b;
        @(negedge i_mclk);
        we = 1'h0;
    endtask
    task issue(input logic [31:0] w, input logic e_sc, input logic e_tr, input logic e_done);
        logic imm;
        // Only the three removed trap encodings are refused in the newer release
        imm = (w[31:26] === trap_unit_pkg::OP_IMMEDIATE_BRANCH) && (w[20:16] === trap_unit_pkg::SUB_TRAP_EQ_IMM
            || w[20:16] === trap_unit_pkg::SUB_TRAP_GE_IMM || w[20:16] === trap_unit_pkg::SUB_TRAP_GEU_IMM);
        @(negedge i_mclk);
        valid = e_done;
        instr = w;
        @(negedge i_mclk);
        valid = 1'h0;
        chk("done", e_done, done);
        chk("system_call_instr", e_sc, sc);
        chk("trap", e_tr, tr);
        chk("reserved", 1'h0, ri);
        chk("done6", e_done, done6);
        chk("syscall6", e_sc, sc6);
        chk("trap6", e_tr & !imm, tr6);
        chk("reserved6", imm & e_done, ri6);
    endtask
    function automatic logic [31:0] rr(logic [5:0] fn, logic [9:0] code);
        return {trap_unit_pkg::OP_SPECIAL, 5'h01, 5'h02, code, fn};
    endfunction
    function automatic logic [31:0] rim(logic [4:0] sub, logic [15:0] imm);
        return {trap_unit_pkg::OP_IMMEDIATE_BRANCH, 5'h01, sub, imm};
    endfunction
    // ==========================================================
    // Scenarios
    task t_eq;
        regs(64'h0000_0000_0000_1234, 64'h0000_0000_0000_1234);
        issue(rr(trap_unit_pkg::FN_TRAP_EQ_REG, 10'h000), 1'h0, 1'h1, 1'h1);
        issue(rr(trap_unit_pkg::FN_TRAP_EQ_REG, 10'h3FF), 1'h0, 1'h1, 1'h1);
        issue({trap_unit_pkg::OP_SPECIAL, 20'h0_0000, trap_unit_pkg::FN_SYSTEM_CALL}, 1'h1, 1'h0, 1'h1);
        issue({trap_unit_pkg::OP_SPECIAL, 20'hF_FFFF, trap_unit_pkg::FN_SYSTEM_CALL}, 1'h1, 1'h0, 1'h1);
        regs(64'h0000_0000_0000_1234, 64'h0000_0000_0000_1235);
        issue(rr(trap_unit_pkg::FN_TRAP_EQ_REG, 10'h155), 1'h0, 1'h0, 1'h1);
        issue(rr(6'h20, 10'h000), 1'h0, 1'h0, 1'h1);
        issue(rr(trap_unit_pkg::FN_TRAP_EQ_REG, 10'h000), 1'h0, 1'h0, 1'h0);
    endtask
    task t_ge;
        regs(ONES, 64'h0000_0000_0000_0001);
        issue(rr(trap_unit_pkg::FN_TRAP_GE_REG, 10'h2AA), 1'h0, 1'h0, 1'h1);
        issue(rr(trap_unit_pkg::FN_TRAP_GEU_REG, 10'h2AA), 1'h0, 1'h1, 1'h1);
        regs(64'h0000_0000_0000_0001, ONES);
        issue(rr(trap_unit_pkg::FN_TRAP_GE_REG, 10'h000), 1'h0, 1'h1, 1'h1);
        issue(rr(trap_unit_pkg::FN_TRAP_GEU_REG, 10'h000), 1'h0, 1'h0, 1'h1);
        regs(64'h0000_0000_0000_0005, 64'h0000_0000_0000_0005);
        issue(rr(trap_unit_pkg::FN_TRAP_GE_REG, 10'h3FF), 1'h0, 1'h1, 1'h1);
        issue(rr(trap_unit_pkg::FN_TRAP_GEU_REG, 10'h3FF), 1'h0, 1'h1, 1'h1);
    endtask
    task t_imm;
        regs(ONES, 64'h0000_0000_0000_0000);
        issue(rim(trap_unit_pkg::SUB_TRAP_EQ_IMM, 16'hFFFF), 1'h0, 1'h1, 1'h1);
        issue(rim(trap_unit_pkg::SUB_TRAP_GE_IMM, 16'h0000), 1'h0, 1'h0, 1'h1);
        issue(rim(trap_unit_pkg::SUB_TRAP_GEU_IMM, 16'hFFFF), 1'h0, 1'h1, 1'h1);
        regs(64'h0000_0000_0000_7FFF, 64'h0000_0000_0000_0000);
        issue(rim(trap_unit_pkg::SUB_TRAP_EQ_IMM, 16'h8000), 1'h0, 1'h0, 1'h1);
        issue(rim(trap_unit_pkg::SUB_TRAP_GE_IMM, 16'h8000), 1'h0, 1'h1, 1'h1);
        issue(rim(trap_unit_pkg::SUB_TRAP_GEU_IMM, 16'h7FFF), 1'h0, 1'h1, 1'h1);
        issue(rim(trap_unit_pkg::SUB_TRAP_GEU_IMM, 16'h8000), 1'h0, 1'h0, 1'h1);
        // A sub-code that is no trap must complete quietly in both releases
        issue(rim(5'h00, 16'h0000), 1'h0, 1'h0, 1'h1);
    endtask
    // ==========================================================
    // Sequence and hang guard
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(negedge i_mclk);
        i_rst_n = 1'h1;
        repeat (3) @(negedge i_mclk);
        t_eq();
        t_ge();
        t_imm();
        wrap_up();
    end
endmodule
